// ===== rtl/perf_sample_ctl.sv
// Purpose: sample enable, freeze on management interrupt, record trigger
// Assumes: counters and descriptor memory outside; one clock
// Notes: record request and reload request are one-cycle pulses
//
// Notes on behaviour
// - capability low six bits: branch format
// - capability bit 6: trap-like indicator
// - capability bit 7: saves architectural registers
// - capability bits 11:8: record format
// - capability bit 12: freeze supported
// - capability bit 13: alternate high write
// - sample enables: gp from 0, fixed from 32
// - data group register exists with baseline
// - capability bit 15: topdown metrics available
// - output select 01 routes to trace
// - capability exists only when presence strap set
// - freeze: clear enables, save, clear debug bits
// - resume: enables set, debug control restored
// - precise: record after causing instruction retires
// - non-precise: record at next opportunity
// - fixed zero precise, other fixed non-precise
// - applicable field matches enable positions
// - reload counter from descriptor area
// - basic group unless adaptive selected
// - data group register selects groups, depth
`timescale 1ns/1ns
`include "perf_sample_map.svh"

module perf_sample_ctl
  import perf_sample_pkg::*;
#(
  parameter int NUM_GP = 4,
  parameter int NUM_FIXED = 3,
  parameter logic [5:0] BR_FORMAT = 6'h05,
  parameter logic [3:0] REC_FORMAT = 4'h4,
  parameter logic CAP_TRAP = 1'b1,
  parameter logic CAP_ARCHREG = 1'b1,
  parameter logic CAP_FREEZE = 1'b1,
  parameter logic CAP_ALTWR = 1'b1,
  parameter logic CAP_BASELINE = 1'b1,
  parameter logic CAP_METRICS = 1'b0,
  parameter logic CAP_TRACE = 1'b1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic [11:0] regAddr,
  input wire logic [63:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [63:0] regRdata,
  // presence strap
  input wire logic capPresent,
  // management mode events
  input wire logic mgmtInterrupt,
  input wire logic resumeFromMgmt,
  // counter events
  input wire logic [63:0] ovfSet,
  input wire logic retireStrobe,
  input wire logic [63:0] adaptiveEn,
  // record and reload requests
  output logic recordReq,
  output logic [63:0] recordCounters,
  output logic [47:0] recordGroups,
  output logic recordToTrace,
  output logic reloadReq,
  output logic [7:0] reloadOffset,
  output logic [63:0] reloadMask,
  // control outputs
  output logic [63:0] globalEnable,
  output logic [63:0] debugControl
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [63:0] sampleEn_q; // per-counter enables
  logic [63:0] dataCfg_q; // data group selection
  logic [63:0] dbg_q; // debug control
  logic [63:0] dbgSave_q; // copy taken at freeze
  logic [63:0] glob_q; // global counter enables
  logic [63:0] ovf_q; // overflow pending
  logic capValid_q; // strap caught after reset
  logic inMgmt_q; // inside management handler
  logic [63:0] rdata_q;
  logic recReq_q;
  logic [63:0] recCnt_q;
  logic [47:0] recGrp_q;
  logic recTrace_q;
  logic rldReq_q;
  logic [7:0] rldOfs_q;
  logic [63:0] rldMask_q;
  rec_state_t st_q;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire wrEn = regWr && regAddr == `OFS_SAMPLE_ENABLE;
  wire wrCfg = regWr && regAddr == `OFS_DATA_GROUP && CAP_BASELINE;
  wire wrDbg = regWr && regAddr == `OFS_DEBUG_CTL;
  wire wrGlob = regWr && regAddr == `OFS_GLOBAL_EN;
  wire wrOvf = regWr && regAddr == `OFS_OVERFLOW;
  wire [63:0] dbgMask = ~(64'(!CAP_FREEZE) << `DBG_FREEZE_BIT);
  wire freezeOn = dbg_q[`DBG_FREEZE_BIT];
  wire freezeEntry = mgmtInterrupt && !inMgmt_q && freezeOn;
  wire freezeExit = resumeFromMgmt && inMgmt_q;

  wire [63:0] dbgClrMask = ~((64'h1 << `DBG_BRREC_BIT) | (64'h1 << `DBG_STEP_BIT)
    | (64'h1 << `DBG_TRACE_BIT) | (64'h1 << `DBG_STORE_BIT));

  wire [63:0] capWord = 64'(BR_FORMAT) << `CAP_BRFMT_LSB
    | 64'(CAP_TRAP) << `CAP_TRAP_BIT
    | 64'(CAP_ARCHREG) << `CAP_ARCHREG_BIT
    | 64'(REC_FORMAT) << `CAP_RECFMT_LSB
    | 64'(CAP_FREEZE) << `CAP_FREEZE_BIT
    | 64'(CAP_ALTWR) << `CAP_ALTWR_BIT
    | 64'(CAP_BASELINE) << `CAP_BASELINE_BIT
    | 64'(CAP_METRICS) << `CAP_METRICS_BIT
    | 64'(CAP_TRACE) << `CAP_TRACE_BIT;

  // counter slots that exist
  wire [63:0] cntMask = 64'((64'h1 << NUM_GP) - 64'h1)
    | (64'((64'h1 << NUM_FIXED) - 64'h1) << `FIXED_LSB);
  wire [63:0] enWriteMask = cntMask | (64'h3 << `OUTSEL_LSB);

  wire [63:0] preciseMask = 64'((64'h1 << NUM_GP) - 64'h1) | (64'h1 << `FIXED_LSB);
  wire [63:0] armed = ovf_q & sampleEn_q & cntMask & glob_q;
  wire [63:0] fire = armed & (retireStrobe ? 64'hffffffffffffffff : ~preciseMask);
  // adaptive when any firing counter asks
  wire adaptive = |(fire & adaptiveEn);

  // lowest firing counter picks the reload slot
  logic [6:0] firstIdx;
  always_comb begin
    firstIdx = 7'h00;
    for (int i = 63; i >= 0; i--) begin
      if (fire[i]) begin
        firstIdx = 7'(i);
      end
    end
  end
  wire [7:0] rldOfs = firstIdx >= 7'd32
    ? 8'(`RELOAD_FIXED_BASE + (firstIdx - 7'd32) * `RELOAD_STEP)
    : 8'(`RELOAD_GP_BASE + firstIdx * `RELOAD_STEP);

  // read mux
  wire [63:0] rdMux =
    regAddr == `OFS_CAPABILITY ? (capValid_q ? capWord : `RST_ZERO) :
    regAddr == `OFS_SAMPLE_ENABLE ? sampleEn_q :
    regAddr == `OFS_DATA_GROUP ? dataCfg_q :
    regAddr == `OFS_DEBUG_CTL ? dbg_q :
    regAddr == `OFS_GLOBAL_EN ? glob_q :
    regAddr == `OFS_STATUS ? {61'h0, inMgmt_q, capValid_q, st_q != REC_IDLE} :
    regAddr == `OFS_OVERFLOW ? ovf_q : `RST_ZERO;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // strap catch and read port
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      capValid_q <= 1'b0;
      rdata_q <= `RST_ZERO;
    end else begin
      capValid_q <= capPresent;
      rdata_q <= regRd ? rdMux : `RST_ZERO;
    end
  end

  // software registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sampleEn_q <= `RST_ZERO;
      dataCfg_q <= `RST_ZERO;
    end else begin
      if (wrEn) begin
        sampleEn_q <= regWdata & enWriteMask;
      end
      if (wrCfg) begin
        dataCfg_q <= regWdata;
      end
    end
  end

  // freeze and restore
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dbg_q <= `RST_ZERO;
      dbgSave_q <= `RST_ZERO;
      glob_q <= `RST_ZERO;
      inMgmt_q <= 1'b0;
    end else if (freezeEntry) begin
      glob_q <= `RST_ZERO;
      dbgSave_q <= dbg_q;
      dbg_q <= dbg_q & dbgClrMask;
      inMgmt_q <= 1'b1;
    end else if (freezeExit) begin
      glob_q <= cntMask;
      dbg_q <= dbgSave_q;
      inMgmt_q <= 1'b0;
    end else begin
      if (wrDbg) begin
        dbg_q <= regWdata & dbgMask;
      end
      if (wrGlob) begin
        glob_q <= regWdata & cntMask;
      end
    end
  end

  // overflow pending: set wins over clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ovf_q <= `RST_ZERO;
    end else begin
      ovf_q <= ((wrOvf ? regWdata : ovf_q) & ~(st_q == REC_IDLE ? fire : 64'h0)) | (ovfSet & cntMask);
    end
  end

  // record sequencer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q <= REC_IDLE;
      recReq_q <= 1'b0;
      recCnt_q <= `RST_ZERO;
      recGrp_q <= 48'h0;
      recTrace_q <= 1'b0;
      rldReq_q <= 1'b0;
      rldOfs_q <= 8'h00;
      rldMask_q <= `RST_ZERO;
    end else begin
      recReq_q <= 1'b0;
      rldReq_q <= 1'b0;
      unique case (st_q)
        REC_IDLE: begin
          if (|fire) begin
            recCnt_q <= fire;
            recGrp_q <= adaptive ? dataCfg_q[47:0] : 48'h0;
            recTrace_q <= CAP_TRACE && sampleEn_q[`OUTSEL_LSB +: 2] == `OUTSEL_TRACE;
            recReq_q <= 1'b1;
            rldOfs_q <= rldOfs;
            st_q <= REC_EMIT;
          end
        end
        REC_EMIT: begin
          rldReq_q <= 1'b1;
          rldMask_q <= recCnt_q;
          st_q <= REC_RELOAD;
        end
        REC_RELOAD: begin
          st_q <= REC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign regRdata = rdata_q;
  assign recordReq = recReq_q;
  assign recordCounters = recCnt_q;
  assign recordGroups = recGrp_q;
  assign recordToTrace = recTrace_q;
  assign reloadReq = rldReq_q;
  assign reloadOffset = rldOfs_q;
  assign reloadMask = rldMask_q;
  assign globalEnable = glob_q;
  assign debugControl = dbg_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_record;
    recordReq ##1 reloadReq;
  endsequence

  a_freeze_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
    freezeEntry |=> globalEnable == 64'h0 && !debugControl[`DBG_BRREC_BIT] && !debugControl[`DBG_STORE_BIT])
    else $error("freeze did not clear enables");
  a_resume_restore: assert property (@(posedge ref_clk) disable iff (!rst_n)
    freezeExit |=> debugControl == $past(dbgSave_q) && globalEnable == cntMask)
    else $error("resume did not restore state");
  a_record_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(recordReq) |-> s_record)
    else $error("reload did not follow record");
  a_precise_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_q == REC_IDLE && !retireStrobe |=> !$rose(recordReq) || (recordCounters & preciseMask) == 64'h0)
    else $error("precise record without retire");
  a_applicable_enabled: assert property (@(posedge ref_clk) disable iff (!rst_n)
    recordReq |-> (recordCounters & ~sampleEn_q) == 64'h0 || $past(wrEn))
    else $error("record names disabled counter");
  a_basic_default: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_q == REC_IDLE && |fire && !adaptive |=> recordGroups == 48'h0)
    else $error("groups set without adaptive");
  a_cap_fields: assert property (@(posedge ref_clk) disable iff (!rst_n)
    regRd && regAddr == `OFS_CAPABILITY && capValid_q |=> regRdata[11:8] == REC_FORMAT && regRdata[5:0] == BR_FORMAT)
    else $error("capability fields wrong");
  a_cap_absent: assert property (@(posedge ref_clk) disable iff (!rst_n)
    regRd && regAddr == `OFS_CAPABILITY && !capValid_q |=> regRdata == 64'h0)
    else $error("capability visible without strap");

endmodule : perf_sample_ctl

// ===== rtl/perf_sample_map.svh
// Purpose: offsets, field positions and reset values of the sampling block
// Assumes: included by the design module and the bench
// Notes: register indices stand at their printed offsets
`ifndef PERF_SAMPLE_MAP_SVH
`define PERF_SAMPLE_MAP_SVH

// register offsets
`define OFS_SAMPLE_ENABLE 12'h3f1
`define OFS_DATA_GROUP 12'h3f2
`define OFS_CAPABILITY 12'h3f0
`define OFS_DEBUG_CTL 12'h3f3
`define OFS_GLOBAL_EN 12'h3f4
`define OFS_STATUS 12'h3f5
`define OFS_OVERFLOW 12'h3f6
`define OFS_RECORD_SEL 12'h3f7

// capability fields
`define CAP_BRFMT_LSB 0
`define CAP_TRAP_BIT 6
`define CAP_ARCHREG_BIT 7
`define CAP_RECFMT_LSB 8
`define CAP_FREEZE_BIT 12
`define CAP_ALTWR_BIT 13
`define CAP_BASELINE_BIT 14
`define CAP_METRICS_BIT 15
`define CAP_TRACE_BIT 16

// debug control fields
`define DBG_BRREC_BIT 0
`define DBG_STEP_BIT 1
`define DBG_TRACE_BIT 6
`define DBG_STORE_BIT 7
`define DBG_FREEZE_BIT 14

// sample enable layout
`define FIXED_LSB 32
`define OUTSEL_LSB 61
`define OUTSEL_TRACE 2'h1

// descriptor area reload offsets
`define RELOAD_GP_BASE 8'h40
`define RELOAD_FIXED_BASE 8'h80
`define RELOAD_STEP 8'h08

// reset values
`define RST_ZERO 64'h0000000000000000

`endif

// ===== rtl/perf_sample_pkg.sv
// Purpose: shared types of the sampling block
// Assumes: nothing
// Notes: numbers live in the map header
package perf_sample_pkg;
  // record generation states
  typedef enum logic [1:0] {
    REC_IDLE,
    REC_EMIT,
    REC_RELOAD
  } rec_state_t;
endpackage : perf_sample_pkg

// ===== verification/tb.sv
// Purpose: self-checking bench for the sampling control block
// Assumes: default parameters; register reads answer one cycle later
// Notes: a record is waited for under a short bounded count
`timescale 1ns/1ns
`include "perf_sample_map.svh"

module tb;
  import perf_sample_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [63:0] regWdata = 64'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [63:0] regRdata;
  logic capPresent = 1'b1;
  logic mgmtInterrupt = 1'b0;
  logic resumeFromMgmt = 1'b0;
  logic [63:0] ovfSet = 64'h0;
  logic retireStrobe = 1'b0;
  logic [63:0] adaptiveEn = 64'h0;
  logic recordReq, recordToTrace, reloadReq;
  logic [63:0] recordCounters, reloadMask, globalEnable, debugControl;
  logic [47:0] recordGroups;
  logic [7:0] reloadOffset;
  int errors = 0;
  int cmp_count = 0;

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  perf_sample_ctl perf_sample_ctl_inst (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .capPresent(capPresent),
    .mgmtInterrupt(mgmtInterrupt), .resumeFromMgmt(resumeFromMgmt), .ovfSet(ovfSet),
    .retireStrobe(retireStrobe), .adaptiveEn(adaptiveEn), .recordReq(recordReq),
    .recordCounters(recordCounters), .recordGroups(recordGroups), .recordToTrace(recordToTrace),
    .reloadReq(reloadReq), .reloadOffset(reloadOffset), .reloadMask(reloadMask),
    .globalEnable(globalEnable), .debugControl(debugControl));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // one comparison, counted
  task chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask : chk

  // one-cycle write strobe
  task wr(input logic [11:0] a, input logic [63:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr

  // one-cycle read strobe, data in the next cycle
  task rd(input logic [11:0] a, output logic [63:0] d);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd

  // one-cycle pulse on overflow, retire or mode events
  task pulse(input logic [63:0] ovf, input logic ret, input logic mgmt_interrupt, input logic resume_from_mgmt);
    @(posedge ref_clk);
    ovfSet <= ovf;
    retireStrobe <= ret;
    mgmtInterrupt <= mgmt_interrupt;
    resumeFromMgmt <= resume_from_mgmt;
    @(posedge ref_clk);
    ovfSet <= 64'h0;
    retireStrobe <= 1'b0;
    mgmtInterrupt <= 1'b0;
    resumeFromMgmt <= 1'b0;
  endtask : pulse

  // wait for a record, then judge it and the reload that follows
  task expect_rec(input logic [63:0] cnt, input logic [47:0] grp, input logic trc, input logic [7:0] ofs);
    int n;
    n = 0;
    // step past the launch edge so a pulse raised there is seen
    #1;
    while (recordReq !== 1'b1 && n < 8) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk("recordReq", 64'h1, {63'h0, recordReq});
    chk("recordCounters", cnt, recordCounters);
    chk("recordGroups", {16'h0, grp}, {16'h0, recordGroups});
    chk("recordToTrace", {63'h0, trc}, {63'h0, recordToTrace});
    chk("reloadOffset", {56'h0, ofs}, {56'h0, reloadOffset});
    @(posedge ref_clk);
    #1 chk("reloadReq", 64'h1, {63'h0, reloadReq});
    chk("reloadMask", cnt, reloadMask);
  endtask : expect_rec

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // capability fields, read-only, unmapped read, presence strap
  task t_capability;
    logic [63:0] d;
    rd(`OFS_CAPABILITY, d);
    chk("capability", 64'h00000000000174c5, d);
    wr(`OFS_CAPABILITY, 64'h0);
    rd(`OFS_CAPABILITY, d);
    chk("capability after write", 64'h00000000000174c5, d);
    rd(12'h0ff, d);
    chk("unmapped read", 64'h0, d);
    @(posedge ref_clk);
    capPresent <= 1'b0;
    rd(`OFS_CAPABILITY, d);
    chk("capability absent", 64'h0, d);
    capPresent <= 1'b1;
    $display("test capability done");
  endtask : t_capability

  // precise gp2 and fixed0 wait for retire, gp2 reload offset
  task t_precise;
    logic [63:0] d;
    wr(`OFS_GLOBAL_EN, 64'h000000070000000f);
    wr(`OFS_SAMPLE_ENABLE, 64'h0000000100000004);
    rd(`OFS_SAMPLE_ENABLE, d);
    chk("sample enable", 64'h0000000100000004, d);
    pulse(64'h0000000100000004, 1'b0, 1'b0, 1'b0);
    repeat (4) begin
      @(posedge ref_clk);
      #1 chk("no record before retire", 64'h0, {63'h0, recordReq});
    end
    pulse(64'h0, 1'b1, 1'b0, 1'b0);
    expect_rec(64'h0000000100000004, 48'h0, 1'b0, 8'h50);
    $display("test precise done");
  endtask : t_precise

  // non-precise fixed1 with adaptive groups and trace output
  task t_nonprecise;
    logic [63:0] d;
    wr(`OFS_DATA_GROUP, 64'h000000000000000f);
    rd(`OFS_DATA_GROUP, d);
    chk("data group cfg", 64'h000000000000000f, d);
    wr(`OFS_SAMPLE_ENABLE, 64'h2000000200000000);
    @(posedge ref_clk);
    adaptiveEn <= 64'h0000000200000000;
    pulse(64'h0000000200000000, 1'b0, 1'b0, 1'b0);
    expect_rec(64'h0000000200000000, 48'h00000000000f, 1'b1, 8'h88);
    // overflow set by a register write records at once
    wr(`OFS_OVERFLOW, 64'h0000000200000000);
    expect_rec(64'h0000000200000000, 48'h00000000000f, 1'b1, 8'h88);
    $display("test nonprecise done");
  endtask : t_nonprecise

  // freeze on management interrupt and restore on resume
  task t_freeze;
    int n;
    wr(`OFS_DEBUG_CTL, 64'h00000000000040cb);
    wr(`OFS_GLOBAL_EN, 64'h0000000300000005);
    pulse(64'h0, 1'b0, 1'b1, 1'b0);
    n = 0;
    while (globalEnable !== 64'h0 && n < 4) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk("frozen enables", 64'h0, globalEnable);
    chk("frozen debug", 64'h0000000000004008, debugControl);
    pulse(64'h0, 1'b0, 1'b0, 1'b1);
    n = 0;
    while (debugControl !== 64'h40cb && n < 4) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk("restored debug", 64'h00000000000040cb, debugControl);
    chk("restored enables", 64'h000000070000000f, globalEnable);
    $display("test freeze done");
  endtask : t_freeze

  // ----------------------------------------
  // verdict
  // ----------------------------------------
  task end_of_test;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_capability();
    t_precise();
    t_nonprecise();
    t_freeze();
    end_of_test();
  end

  // watchdog
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    end_of_test();
  end
endmodule : tb
